// ### core/signaling_pin_interface.sv
`timescale 1ns/10ps
`include "sig_pin_defines.svh"

// Functional notes
// - writing output register drives dedicated command pins
// - low register maps x_1/x_0 per channel
// - reads return debounced status of input pins
// - writes drive only pins configured as outputs
// - direction bit: zero input, one output
// - reset makes every programmable pin input
// - high register: x_2 values and directions
// - stable change updates status, raises pair interrupt for input pins only
// - debounce interval is two ms times code
// - code zero disables debounce and interrupts
// - config register also holds ring field
// - ring: 0 high, 15 low, else square
// - command: rw, length, registers sent highest first
module signaling_pin_interface #(
	parameter int NUM_CH = 4,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// clock, reset, enable
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// serial control interface
	input wire logic SER_CS_N,
	input wire logic SER_CLK,
	input wire logic SER_DIN,
	output logic SER_DOUT,
	output logic SER_DOUT_OE,
	// dedicated command outputs
	output logic [7:0] CMD_OUT,
	// programmable bidirectional pins
	input wire logic [11:0] SIG_PIN_IN,
	output logic [11:0] SIG_PIN_OUT,
	output logic [11:0] SIG_PIN_OE,
	// interrupts
	output logic IRQ_PAIR_A,
	output logic IRQ_PAIR_B,
	// ring generator
	output logic RING_TONE_OUTPUT
);

	localparam int TW = (MS_CYCLES > 2) ? $clog2(MS_CYCLES) : 1;
	localparam logic [7:0] MASK_LO = (NUM_CH == 4) ? `MASK_LOW_4CH : `MASK_LOW_2CH;
	localparam logic [3:0] MASK_HI = (NUM_CH == 4) ? `MASK_HI_4CH : `MASK_HI_2CH;

	if (NUM_CH != 2 && NUM_CH != 4) begin : g_chk_ch
		$error("signaling_pin_interface: NUM_CH must be 2 or 4");
	end
	if (MS_CYCLES < 2) begin : g_chk_ms
		$error("signaling_pin_interface: MS_CYCLES must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [14:0] sync1_ff;
	logic [14:0] sync2_ff;
	logic clk_d_ff;
	logic [11:0] s_pins;
	logic s_din;
	logic s_clk;
	logic s_cs_n;
	logic sclk_rise;
	logic sclk_fall;

	logic [TW-1:0] tick_cnt_ff;
	logic tick_ff;

	sig_pin_pkg::ser_state_t state_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] rx_byte;
	logic rw_ff;
	sig_pin_pkg::reg_idx_t idx_ff;
	logic soft_rst_ff;
	logic rd_cmd_ff;
	logic wr_en_ff;
	sig_pin_pkg::reg_idx_t wr_idx_ff;
	logic [7:0] wr_data_ff;

	logic [7:0] tx_ff;
	logic dout_ff;
	logic oe_ff;
	logic [7:0] rd_byte;

	logic [7:0] cmd_ff;
	logic [7:0] val_lo_ff;
	logic [7:0] dir_lo_ff;
	logic [3:0] val_hi_ff;
	logic [3:0] dir_hi_ff;
	logic [7:0] cfg_ff;

	logic [11:0] stat;
	logic [11:0] chg;
	logic [11:0] dir_all;
	logic [11:0] in_chg;
	logic irq_a_ff;
	logic irq_b_ff;
	logic ring;

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers, order {cs_n, sclk, din, pins}

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_ff <= 15'h4000;
			sync2_ff <= 15'h4000;
			clk_d_ff <= 1'b0;
		end else if (CE) begin
			sync1_ff <= {SER_CS_N, SER_CLK, SER_DIN, SIG_PIN_IN};
			sync2_ff <= sync1_ff;
			clk_d_ff <= sync2_ff[13];
		end
	end

	// synchronised views and serial clock edges
	assign s_pins = sync2_ff[11:0];
	assign s_din = sync2_ff[12];
	assign s_clk = sync2_ff[13];
	assign s_cs_n = sync2_ff[14];
	assign sclk_rise = s_clk & ~clk_d_ff;
	assign sclk_fall = ~s_clk & clk_d_ff;
	assign rx_byte = {shift_ff[6:0], s_din};

	////////////////////////////////////////////////////////////////////////////
	// millisecond tick from the master clock

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (CE) begin
			if (tick_cnt_ff == TW'(MS_CYCLES - 1)) begin
				tick_cnt_ff <= '0;
				tick_ff <= 1'b1;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 1'b1;
				tick_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial command decoder, msb first, sampled on rising sclk

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= sig_pin_pkg::ST_IDLE;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			rw_ff <= 1'b0;
			idx_ff <= 3'h0;
			soft_rst_ff <= 1'b0;
			rd_cmd_ff <= 1'b0;
			wr_en_ff <= 1'b0;
			wr_idx_ff <= 3'h0;
			wr_data_ff <= 8'h00;
		end else if (CE) begin
			soft_rst_ff <= 1'b0;
			rd_cmd_ff <= 1'b0;
			wr_en_ff <= 1'b0;
			if (s_cs_n) begin
				state_ff <= sig_pin_pkg::ST_IDLE;
				bit_cnt_ff <= 3'h0;
			end else if (state_ff == sig_pin_pkg::ST_IDLE) begin
				state_ff <= sig_pin_pkg::ST_CMD;
				bit_cnt_ff <= 3'h0;
			end else if (sclk_rise) begin
				shift_ff <= rx_byte;
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == 3'h7) begin
					case (state_ff)
						sig_pin_pkg::ST_CMD: begin
							if (rx_byte[`CMD_MARK_HI:`CMD_MARK_LO] != `CMD_MARK) begin
								state_ff <= sig_pin_pkg::ST_DONE;
							end else if (rx_byte[`CMD_RST_BIT]) begin
								soft_rst_ff <= 1'b1;
								state_ff <= sig_pin_pkg::ST_DONE;
							end else begin
								// length code n: n+1 bytes, index n first
								rw_ff <= rx_byte[`CMD_RW_BIT];
								idx_ff <= rx_byte[`CMD_LEN_HI:`CMD_LEN_LO];
								rd_cmd_ff <= rx_byte[`CMD_RW_BIT];
								state_ff <= sig_pin_pkg::ST_DATA;
							end
						end
						sig_pin_pkg::ST_DATA: begin
							wr_en_ff <= ~rw_ff;
							wr_idx_ff <= idx_ff;
							wr_data_ff <= rx_byte;
							// count down to register 0, then ignore the rest
							if (idx_ff == 3'h0) begin
								state_ff <= sig_pin_pkg::ST_DONE;
							end else begin
								idx_ff <= idx_ff - 3'h1;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data: outputs return written value, inputs debounced status

	always_comb begin
		rd_byte = 8'h00;
		case (idx_ff)
			`IDX_VAL_LOW: rd_byte = ((dir_lo_ff & val_lo_ff) | (~dir_lo_ff & stat[7:0])) & MASK_LO;
			`IDX_DIR: rd_byte = dir_lo_ff;
			`IDX_VAL_HI: rd_byte = {((dir_hi_ff & val_hi_ff) | (~dir_hi_ff & stat[11:8])) & MASK_HI,
				dir_hi_ff};
			`IDX_DEB_RING: rd_byte = cfg_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// serial output, shifted on falling sclk, byte loaded at bit 0

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_ff <= 8'h00;
			dout_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (CE) begin
			oe_ff <= (state_ff == sig_pin_pkg::ST_DATA) && rw_ff && !s_cs_n;
			if (sclk_fall && state_ff == sig_pin_pkg::ST_DATA && rw_ff) begin
				if (bit_cnt_ff == 3'h0) begin
					dout_ff <= rd_byte[7];
					tx_ff <= {rd_byte[6:0], 1'b0};
				end else begin
					dout_ff <= tx_ff[7];
					tx_ff <= {tx_ff[6:0], 1'b0};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// extended registers, cleared by either reset

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_ff <= `REG_RESET;
			val_lo_ff <= `REG_RESET;
			dir_lo_ff <= `REG_RESET;
			val_hi_ff <= 4'h0;
			dir_hi_ff <= 4'h0;
			cfg_ff <= `REG_RESET;
		end else if (CE) begin
			if (soft_rst_ff) begin
				cmd_ff <= `REG_RESET;
				val_lo_ff <= `REG_RESET;
				dir_lo_ff <= `REG_RESET;
				val_hi_ff <= 4'h0;
				dir_hi_ff <= 4'h0;
				cfg_ff <= `REG_RESET;
			end else if (wr_en_ff) begin
				case (wr_idx_ff)
					`IDX_CMD_OUT: cmd_ff <= wr_data_ff & MASK_LO;
					`IDX_VAL_LOW: val_lo_ff <= wr_data_ff & MASK_LO;
					`IDX_DIR: dir_lo_ff <= wr_data_ff & MASK_LO;
					`IDX_VAL_HI: begin
						val_hi_ff <= wr_data_ff[7:4] & MASK_HI;
						dir_hi_ff <= wr_data_ff[3:0] & MASK_HI;
					end
					// reserved debounce codes are stored as written
					`IDX_DEB_RING: cfg_ff <= wr_data_ff;
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drivers: enable follows the direction bit

	assign dir_all = {dir_hi_ff, dir_lo_ff};
	assign SIG_PIN_OUT = {val_hi_ff, val_lo_ff};
	assign SIG_PIN_OE = dir_all;
	assign CMD_OUT = cmd_ff;
	assign SER_DOUT = dout_ff;
	assign SER_DOUT_OE = oe_ff;

	////////////////////////////////////////////////////////////////////////////
	// one debouncer per present pin

	for (genvar i = 0; i < 12; i++) begin : g_deb
		if ((i < 8 && (i / 2) < NUM_CH) || (i >= 8 && (i - 8) < NUM_CH)) begin : g_on
			sig_debounce #(
				.CODE_W(4)
			) u_deb (
				.clk(CLK),
				.rst_n(RST_N),
				.ce(CE),
				.soft_rst(soft_rst_ff),
				.tick(tick_ff),
				.pin(s_pins[i]),
				.code(cfg_ff[`DEB_HI:`DEB_LO]),
				.status(stat[i]),
				.changed(chg[i])
			);
		end else begin : g_off
			assign stat[i] = 1'b0;
			assign chg[i] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pair interrupts: set on debounced input change, cleared by a read command

	assign in_chg = chg & ~dir_all;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_a_ff <= 1'b0;
			irq_b_ff <= 1'b0;
		end else if (CE) begin
			if (soft_rst_ff) begin
				irq_a_ff <= 1'b0;
				irq_b_ff <= 1'b0;
			end else begin
				// set wins over the clear
				irq_a_ff <= (|(in_chg & `PAIR_A_PINS)) | (irq_a_ff & ~rd_cmd_ff);
				irq_b_ff <= (|(in_chg & `PAIR_B_PINS)) | (irq_b_ff & ~rd_cmd_ff);
			end
		end
	end

	assign IRQ_PAIR_A = irq_a_ff;
	assign IRQ_PAIR_B = irq_b_ff;

	////////////////////////////////////////////////////////////////////////////
	// ring generator

	ring_tone_gen u_ring (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.soft_rst(soft_rst_ff),
		.tick(tick_ff),
		.code(cfg_ff[`RING_HI:`RING_LO]),
		.ring(ring)
	);

	assign RING_TONE_OUTPUT = ring;

endmodule

// ### core/sig_pin_defines.svh
`ifndef SIG_PIN_DEFINES_SVH
`define SIG_PIN_DEFINES_SVH

// extended register indices
`define IDX_CMD_OUT 3'h0
`define IDX_VAL_LOW 3'h1
`define IDX_DIR 3'h2
`define IDX_VAL_HI 3'h3
`define IDX_DEB_RING 3'h4

// extended-op command byte layout
`define CMD_RST_BIT 7
`define CMD_RW_BIT 6
`define CMD_MARK_HI 5
`define CMD_MARK_LO 4
`define CMD_MARK 2'h3
`define CMD_LEN_HI 2
`define CMD_LEN_LO 0

// debounce / ring field positions inside the config register
`define DEB_HI 7
`define DEB_LO 4
`define RING_HI 3
`define RING_LO 0

// reset value of every register
`define REG_RESET 8'h00

// per-channel presence masks
`define MASK_LOW_4CH 8'hff
`define MASK_LOW_2CH 8'h0f
`define MASK_HI_4CH 4'hf
`define MASK_HI_2CH 4'h3

// pins belonging to each interrupt pair, order {x2[3:0], low[7:0]}
`define PAIR_A_PINS 12'h30f
`define PAIR_B_PINS 12'hcf0

// ring codes with a constant level
`define RING_CODE_HIGH 4'h0
`define RING_CODE_LOW 4'hf

// time base
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000000
`define MS_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define DEB_UNIT_MS 2
`define RING_HALF_UNIT_MS 1

`endif

// ### core/sig_pin_pkg.sv
package sig_pin_pkg;

	// serial command interface states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_DATA = 2'b10,
		ST_DONE = 2'b11
	} ser_state_t;

	typedef logic [2:0] reg_idx_t;

endpackage

// ### core/sig_debounce.sv
`timescale 1ns/10ps
`include "sig_pin_defines.svh"

module sig_debounce #(
	parameter int CODE_W = 4
) (
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic soft_rst,
	input wire logic tick,
	// pin and interval
	input wire logic pin,
	input wire logic [CODE_W-1:0] code,
	// debounced result
	output logic status,
	output logic changed
);

	logic cand_ff;
	logic status_ff;
	logic changed_ff;
	logic [CODE_W:0] cnt_ff;
	logic [CODE_W:0] limit;

	if (CODE_W < 1) begin : g_chk
		$error("sig_debounce: CODE_W must be at least 1");
	end

	// interval in ms: two ms per code step
	assign limit = (CODE_W + 1)'(32'(code) * `DEB_UNIT_MS);
	assign status = status_ff;
	assign changed = changed_ff;

	////////////////////////////////////////////////////////////////////////////
	// stability timer and status update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_ff <= 1'b0;
			status_ff <= 1'b0;
			changed_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (ce) begin
			changed_ff <= 1'b0;
			if (soft_rst) begin
				cand_ff <= 1'b0;
				status_ff <= 1'b0;
				cnt_ff <= '0;
			end else if (code == '0) begin
				// no debounce: status follows pin, no change event
				status_ff <= pin;
				cand_ff <= pin;
				cnt_ff <= '0;
			end else if (pin != cand_ff) begin
				// new level restarts the timer
				cand_ff <= pin;
				cnt_ff <= '0;
			end else if (cand_ff != status_ff && tick) begin
				if (cnt_ff + 1'b1 >= limit) begin
					status_ff <= cand_ff;
					changed_ff <= 1'b1;
					cnt_ff <= '0;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end

endmodule

// ### core/ring_tone_gen.sv
`timescale 1ns/10ps
`include "sig_pin_defines.svh"

module ring_tone_gen (
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic soft_rst,
	input wire logic tick,
	// waveform code
	input wire logic [3:0] code,
	// ring output
	output logic ring
);

	logic ring_ff;
	logic [3:0] cnt_ff;
	logic [3:0] half;

	// half period in ms equals the code, so full period is 2 ms per step
	assign half = 4'(32'(code) * `RING_HALF_UNIT_MS);
	assign ring = ring_ff;

	////////////////////////////////////////////////////////////////////////////
	// square wave or constant level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_ff <= 1'b1;
			cnt_ff <= 4'h0;
		end else if (ce) begin
			if (soft_rst || code == `RING_CODE_HIGH) begin
				ring_ff <= 1'b1;
				cnt_ff <= 4'h0;
			end else if (code == `RING_CODE_LOW) begin
				ring_ff <= 1'b0;
				cnt_ff <= 4'h0;
			end else if (tick) begin
				if (cnt_ff + 4'h1 >= half) begin
					ring_ff <= ~ring_ff;
					cnt_ff <= 4'h0;
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
		end
	end

endmodule

// ### tb/sig_pin_props.sv
`timescale 1ns/10ps
`include "sig_pin_defines.svh"

module sig_pin_props #(
	parameter int NUM_CH = 4,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// serial interface
	input wire logic SER_CS_N,
	input wire logic SER_DOUT_OE,
	// pins
	input wire logic [7:0] CMD_OUT,
	input wire logic [11:0] SIG_PIN_IN,
	input wire logic [11:0] SIG_PIN_OUT,
	input wire logic [11:0] SIG_PIN_OE,
	// events
	input wire logic IRQ_PAIR_A,
	input wire logic IRQ_PAIR_B,
	input wire logic RING_TONE_OUTPUT
);
	localparam logic [11:0] OE_MASK = (NUM_CH == 2) ? {`MASK_HI_2CH, `MASK_LOW_2CH} : 12'hfff;
	localparam logic [7:0] CMD_MASK = (NUM_CH == 2) ? `MASK_LOW_2CH : `MASK_LOW_4CH;
	logic [1:0][11:0] pair_in;
	logic [1:0][11:0] prev_ff;
	logic [1:0][15:0] stab_ff;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	//////////////////////////////////////////
	// input pins of each pair, masked to inputs
	assign pair_in = {SIG_PIN_IN & ~SIG_PIN_OE & `PAIR_B_PINS, SIG_PIN_IN & ~SIG_PIN_OE & `PAIR_A_PINS};

	// cycles each pair has held still
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev_ff <= '0;
			stab_ff <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (pair_in[p] != prev_ff[p]) begin
					stab_ff[p] <= 16'h0000;
				end else if (stab_ff[p] != 16'hffff) begin
					stab_ff[p] <= stab_ff[p] + 16'h0001;
				end
			end
			prev_ff <= pair_in;
		end
	end

	//////////////////////////////////////////
	a_reset_all_input: assert property ($rose(RST_N) |-> SIG_PIN_OE == 12'h000 && !IRQ_PAIR_A)
		else $error("pins not inputs after reset");
	a_ch_mask_zero: assert property ((SIG_PIN_OE & ~OE_MASK) == 12'h000 && (CMD_OUT & ~CMD_MASK) == 8'h00)
		else $error("absent channel pin active");
	a_irq_a_settle: assert property ($rose(IRQ_PAIR_A) |-> stab_ff[0] >= MS_CYCLES)
		else $error("pair a interrupt before inputs settled");
	a_irq_b_settle: assert property ($rose(IRQ_PAIR_B) |-> stab_ff[1] >= MS_CYCLES)
		else $error("pair b interrupt before inputs settled");
	a_dout_oe_idle: assert property (SER_CS_N [*8] |-> !SER_DOUT_OE)
		else $error("data out enabled while deselected");
	a_irq_a_clear: assert property ($fell(IRQ_PAIR_A) |-> ##[0:8] SER_DOUT_OE)
		else $error("pair a interrupt cleared without read");
	a_irq_b_clear: assert property ($fell(IRQ_PAIR_B) |-> ##[0:8] SER_DOUT_OE)
		else $error("pair b interrupt cleared without read");
	a_pins_hold_idle: assert property (SER_CS_N [*8] |-> $stable(SIG_PIN_OE) && $stable(CMD_OUT) && $stable(SIG_PIN_OUT))
		else $error("pins changed without a write");

	// main scenarios
	c_irq_a: cover property ($rose(IRQ_PAIR_A));
	c_irq_b: cover property ($rose(IRQ_PAIR_B));
	c_ring: cover property ($changed(RING_TONE_OUTPUT));
	c_read: cover property ($rose(SER_DOUT_OE));
endmodule

bind signaling_pin_interface sig_pin_props #(.NUM_CH(NUM_CH), .MS_CYCLES(MS_CYCLES)) u_props (
	.CLK(CLK),
	.RST_N(RST_N),
	.SER_CS_N(SER_CS_N),
	.SER_DOUT_OE(SER_DOUT_OE),
	.CMD_OUT(CMD_OUT),
	.SIG_PIN_IN(SIG_PIN_IN),
	.SIG_PIN_OUT(SIG_PIN_OUT),
	.SIG_PIN_OE(SIG_PIN_OE),
	.IRQ_PAIR_A(IRQ_PAIR_A),
	.IRQ_PAIR_B(IRQ_PAIR_B),
	.RING_TONE_OUTPUT(RING_TONE_OUTPUT)
);

// ### tb/slic_model.sv
`timescale 1ns/10ps

module slic_model (
	// device side of the pins
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe,
	// levels the line circuit indicates
	input wire logic [11:0] ind_lvl,
	// resolved wire level
	output logic [11:0] pin_lvl
);
	// device wins where it drives, line circuit elsewhere
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ind_lvl);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
	localparam int MS = 10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n = 1'b1;
	logic sck = 1'b0;
	logic sdi = 1'b0;
	logic [11:0] lvl = 12'h000;
	logic sdo, sdo_oe, irq_a, irq_b, ring;
	logic [7:0] cmd_out;
	logic [11:0] pin_out, pin_oe, pin_lvl;
	logic [7:0] rd [8];
	logic [7:0] wr [8];
	int n_mismatch = 0;
	int checked = 0;

	// free-running clock
	always #10 clk = ~clk;

	////////////////////////////////////////
	signaling_pin_interface #(.NUM_CH(4), .MS_CYCLES(MS)) dut (
		.CLK(clk),
		.RST_N(rst_n),
		.CE(1'b1),
		.SER_CS_N(cs_n),
		.SER_CLK(sck),
		.SER_DIN(sdi),
		.SER_DOUT(sdo),
		.SER_DOUT_OE(sdo_oe),
		.CMD_OUT(cmd_out),
		.SIG_PIN_IN(pin_lvl),
		.SIG_PIN_OUT(pin_out),
		.SIG_PIN_OE(pin_oe),
		.IRQ_PAIR_A(irq_a),
		.IRQ_PAIR_B(irq_b),
		.RING_TONE_OUTPUT(ring)
	);

	slic_model u_slic (.pin_out(pin_out), .pin_oe(pin_oe), .ind_lvl(lvl), .pin_lvl(pin_lvl));

	////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// output under watch: 0 pair a irq, 1 pair b irq, else ring
	function automatic logic watched(input int which);
		return (which == 0) ? irq_a : (which == 1) ? irq_b : ring;
	endfunction

	// bounded wait, sampled on the falling edge
	task automatic wait_lvl(input int which, input logic want, output int cnt);
		cnt = 0;
		while (watched(which) !== want) begin
			@(negedge clk);
			cnt++;
			if (cnt > 400) begin
				n_mismatch++;
				$display("CHECK FAILED wait %0d expected %b seen %b", which, want, watched(which));
				give_verdict();
			end
		end
		@(posedge clk);
	endtask

	// one byte, msb first, read bit taken late in the high phase
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			sdi <= b[i];
			tick(5);
			sck <= 1'b1;
			tick(5);
			r[i] = sdo;
		end
	endtask

	// command byte then registers len..0
	task automatic extended_op_command(input logic [7:0] cmd);
		logic [7:0] junk;
		cs_n <= 1'b0;
		tick(5);
		xbyte(cmd, junk);
		for (int k = cmd[2:0]; k >= 0; k--) xbyte(wr[k], rd[k]);
		sck <= 1'b0;
		tick(5);
		cs_n <= 1'b1;
		tick(8);
	endtask

	task automatic check_cleared(input string name);
		extended_op_command(8'h77);
		for (int k = 0; k < 8; k++) cmp("reg cleared", 12'h000, {4'h0, rd[k]});
		cmp("oe cleared", 12'h000, pin_oe);
		cmp("ring high", 12'h001, {11'h0, ring});
		$display("test %s done", name);
	endtask

	function automatic logic [11:0] exp_rd(input logic [11:0] dir, input logic [11:0] val, input logic [11:0] pins);
		return (dir & val) | (~dir & pins);
	endfunction

	////////////////////////////////////////
	initial begin
		logic [11:0] dir, val, e;
		logic [7:0] co;
		logic [3:0] codes [4];
		int cnt;
		void'($urandom(85292));
		codes = '{4'h0, 4'hf, 4'h1, 4'h3};
		for (int k = 0; k < 8; k++) wr[k] = 8'h00;
		tick(2);
		rst_n <= 1'b1;
		tick(2);
		check_cleared("reset");
		// random pin setups, corners first
		for (int i = 0; i < 6; i++) begin
			dir = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom());
			val = 12'($urandom());
			co = 8'($urandom());
			lvl <= 12'($urandom());
			wr[3] = {val[11:8], dir[11:8]};
			wr[2] = dir[7:0];
			wr[1] = val[7:0];
			wr[0] = co;
			extended_op_command(8'h33);
			cmp("cmd out", {4'h0, co}, {4'h0, cmd_out});
			cmp("pin oe", dir, pin_oe);
			cmp("pin out", dir & val, dir & pin_out);
			cmp("no irq", 12'h000, {10'h0, irq_b, irq_a});
			extended_op_command(8'h77);
			e = exp_rd(dir, val, lvl);
			cmp("reg1", {4'h0, e[7:0]}, {4'h0, rd[1]});
			cmp("reg2", {4'h0, dir[7:0]}, {4'h0, rd[2]});
			cmp("reg3", {4'h0, e[11:8], dir[11:8]}, {4'h0, rd[3]});
			cmp("reg0 4..7", 12'h000, {4'h0, rd[0] | rd[4] | rd[5] | rd[6] | rd[7]});
		end
		$display("test pins done");
		// debounce with a restart inside the interval
		lvl <= 12'h000;
		for (int k = 0; k < 8; k++) wr[k] = 8'h00;
		extended_op_command(8'h33);
		wr[4] = 8'h20; // code 2 stays below the reserved codes
		extended_op_command(8'h34);
		lvl[0] <= 1'b1;
		tick(15);
		// glitch shorter than the interval, then a new level
		lvl[0] <= 1'b0;
		tick(5);
		cmp("glitch filtered", 12'h000, {10'h0, irq_b, irq_a});
		lvl[1:0] <= 2'b11;
		tick(25);
		cmp("irq early", 12'h000, {10'h0, irq_b, irq_a});
		wait_lvl(0, 1'b1, cnt);
		cmp("irq a delay", 12'h001, {11'h0, cnt + 25 >= 3 * MS && cnt + 25 <= 4 * MS + 6});
		cmp("irq b idle", 12'h000, {11'h0, irq_b});
		extended_op_command(8'h71);
		cmp("reg1 debounced", 12'h003, {4'h0, rd[1]});
		cmp("irq a cleared", 12'h000, {11'h0, irq_a});
		lvl[10] <= 1'b1;
		tick(1);
		wait_lvl(1, 1'b1, cnt);
		cmp("irq b delay", 12'h001, {11'h0, cnt + 1 >= 3 * MS && cnt + 1 <= 4 * MS + 6});
		cmp("irq a idle", 12'h000, {11'h0, irq_a});
		extended_op_command(8'h73);
		cmp("reg3 debounced", 12'h040, {4'h0, rd[3]});
		$display("test debounce done");
		// ring generator codes
		for (int i = 0; i < 4; i++) begin
			wr[4] = {4'h1, codes[i]};
			// write the codes, then read them back
			extended_op_command(8'h34);
			extended_op_command(8'h74);
			cmp("reg4", {4'h0, wr[4]}, {4'h0, rd[4]});
			if (codes[i] == 4'h0 || codes[i] == 4'hf) begin
				cmp("ring level", {11'h0, codes[i] == 4'h0}, {11'h0, ring});
			end else begin
				wait_lvl(2, ~ring, cnt);
				wait_lvl(2, ~ring, cnt);
				cmp("ring half period", 12'(codes[i] * MS), 12'(cnt));
			end
		end
		$display("test ring done");
		// software reset clears everything
		wr[3] = 8'h0f;
		wr[2] = 8'hff;
		extended_op_command(8'h33);
		// quiet line levels while the pins are still outputs
		lvl <= 12'h000;
		wr[0] = 8'h00;
		extended_op_command(8'hb0);
		check_cleared("soft reset");
		give_verdict();
	end
endmodule
